// *** rtl/ltrx_settings_regs.sv ***
// receiver and transmitter settings registers of a 2:1 link switch
// assumes the serial slave front end hands over byte reads and writes
// as one-cycle strobes, and that the source select comes from the
// device-mode register logic (input A after reset)
`include "ltrx_consts.svh"

module ltrx_settings_regs
  import ltrx_pkg::*;
#(
  parameter int TERM_PULSE_CYC =
    (`LTRX_CLK_HZ / 1000) * `LTRX_TERM_PULSE_MS,
  parameter logic [15:0] UPD_DLY_CYC = `LTRX_UPD_DLY_CYC
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire ltrx_byte_t reg_addr_i,
  input wire ltrx_byte_t reg_wdata_i,
  input wire logic hs_src_sel_i,
  output ltrx_byte_t reg_rdata_o,
  output logic [3:0] in_a_term_en_o,
  output logic [3:0] in_b_term_en_o,
  output logic [3:0] in_a_eq_high_o,
  output logic [3:0] in_b_eq_high_o,
  output ltrx_preemph_t output_preemph_level_o,
  output logic output_term_enable_o,
  output logic output_drive_current_o,
  output logic term_pulse_active_o
);

  localparam int PCW = $clog2(TERM_PULSE_CYC + 1);
  localparam logic [PCW-1:0] PULSE_LOAD = PCW'(TERM_PULSE_CYC);

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  wire sel_rx = (reg_addr_i == `LTRX_ADDR_RX_SET);
  wire sel_pt = (reg_addr_i == `LTRX_ADDR_PULSE_SEL);
  wire sel_eq = (reg_addr_i == `LTRX_ADDR_EQ_LVL);
  wire sel_tx = (reg_addr_i == `LTRX_ADDR_TX_SET);

  ltrx_byte_t rx_sh, pt_sh, eq_sh, tx_sh;
  ltrx_byte_t rx_app, pt_app, eq_app, tx_app;

  // ----------------------------------------------------------------------
  // registers with update windows
  // ----------------------------------------------------------------------
  ltrx_upd_delay #(.RST_VAL(`LTRX_RST_RX_SET), .DLY_CYC(UPD_DLY_CYC))
    u_rx_set (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .clk_en_i(clk_en_i),
    .wr_i(reg_wr_i && sel_rx),
    .wdata_i(reg_wdata_i),
    .shadow_o(rx_sh),
    .applied_o(rx_app),
    .busy_o()
  );

  ltrx_upd_delay #(.RST_VAL(`LTRX_RST_PULSE_SEL), .DLY_CYC(UPD_DLY_CYC))
    u_pulse_sel (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .clk_en_i(clk_en_i),
    .wr_i(reg_wr_i && sel_pt),
    .wdata_i(reg_wdata_i),
    .shadow_o(pt_sh),
    .applied_o(pt_app),
    .busy_o()
  );

  ltrx_upd_delay #(.RST_VAL(`LTRX_RST_EQ_LVL), .DLY_CYC(UPD_DLY_CYC))
    u_eq_lvl (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .clk_en_i(clk_en_i),
    .wr_i(reg_wr_i && sel_eq),
    .wdata_i(reg_wdata_i),
    .shadow_o(eq_sh),
    .applied_o(eq_app),
    .busy_o()
  );

  ltrx_upd_delay #(.RST_VAL(`LTRX_RST_TX_SET), .DLY_CYC(UPD_DLY_CYC))
    u_tx_set (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .clk_en_i(clk_en_i),
    .wr_i(reg_wr_i && sel_tx),
    .wdata_i(reg_wdata_i),
    .shadow_o(tx_sh),
    .applied_o(tx_app),
    .busy_o()
  );

  // ----------------------------------------------------------------------
  // termination pulse timer
  // ----------------------------------------------------------------------
  logic src_prev_r;
  logic [PCW-1:0] pulse_cnt_r;
  logic [PCW-1:0] pulse_cnt_nxt;
  wire src_chg = (hs_src_sel_i != src_prev_r);
  wire pulse_on = (pulse_cnt_r != '0);

  // a new switch during a pulse reloads the full period
  assign pulse_cnt_nxt = src_chg ? PULSE_LOAD :
                         pulse_on ? pulse_cnt_r - PCW'(1) : '0;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      src_prev_r <= 1'b0;
      pulse_cnt_r <= '0;
    end else if (clk_en_i) begin
      src_prev_r <= hs_src_sel_i;
      pulse_cnt_r <= pulse_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // per-channel termination and equalizer selects
  // ----------------------------------------------------------------------
  wire rx_term = rx_app[`LTRX_RX_TERM_BIT];
  logic [3:0] term_a_nxt, term_b_nxt, eq_a_nxt, eq_b_nxt;

  for (genvar k = 0; k < `LTRX_CH_PER_IN; k++) begin : g_ch
    // input B channels run in reverse bit order from bit 7 down
    assign term_a_nxt[k] =
      rx_term && !(pulse_on && pt_app[k]);
    assign term_b_nxt[k] =
      rx_term && !(pulse_on && pt_app[7-k]);
    assign eq_a_nxt[k] = eq_app[k];
    assign eq_b_nxt[k] = eq_app[7-k];
  end

  ltrx_byte_t rdata_nxt;
  assign rdata_nxt = sel_rx ? rx_sh :
                     sel_pt ? pt_sh :
                     sel_eq ? eq_sh :
                     sel_tx ? tx_sh : `LTRX_RD_ZERO;

  // ----------------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= `LTRX_RD_ZERO;
      in_a_term_en_o <= 4'hF;
      in_b_term_en_o <= 4'hF;
      in_a_eq_high_o <= 4'h0;
      in_b_eq_high_o <= 4'h0;
      output_preemph_level_o <= LTRX_PE_0DB;
      output_term_enable_o <= 1'b1;
      output_drive_current_o <= 1'b1;
      term_pulse_active_o <= 1'b0;
    end else if (clk_en_i) begin
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_nxt;
      end
      in_a_term_en_o <= term_a_nxt;
      in_b_term_en_o <= term_b_nxt;
      in_a_eq_high_o <= eq_a_nxt;
      in_b_eq_high_o <= eq_b_nxt;
      output_preemph_level_o <=
        ltrx_preemph_t'(tx_app[`LTRX_OUTPUT_PREEMPH_LEVEL_MSB:`LTRX_OUTPUT_PREEMPH_LEVEL_LSB]);
      output_term_enable_o <= tx_app[`LTRX_TX_TERM_BIT];
      output_drive_current_o <= tx_app[`LTRX_TX_CUR_BIT];
      term_pulse_active_o <= pulse_on;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic first_r;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  a_reset_dflt: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    first_r |-> in_a_term_en_o == 4'hF && in_b_term_en_o == 4'hF &&
      in_a_eq_high_o == 4'h0 && in_b_eq_high_o == 4'h0 &&
      output_preemph_level_o == LTRX_PE_0DB && output_term_enable_o &&
      output_drive_current_o)
    else $error("outputs not at default state after reset");

  a_term_off: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (clk_en_i && !rx_term) |=> in_a_term_en_o == 4'h0 && in_b_term_en_o == 4'h0)
    else $error("input termination on while disabled");

  a_pulse_load: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (clk_en_i && src_chg) |=> pulse_cnt_r == PULSE_LOAD ##1
      (pulse_cnt_r == PULSE_LOAD - PCW'(1) || !$past(clk_en_i) ||
       $past(src_chg)))
    else $error("pulse timer not loaded on source change");

  a_term_pulsed: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (clk_en_i && rx_term && pulse_on && pt_app[0] && pt_app[7])
      |=> !in_a_term_en_o[0] && !in_b_term_en_o[0])
    else $error("selected channel not disconnected during pulse");

  a_term_kept: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (clk_en_i && rx_term && !pt_app[3] && !pt_app[4])
      |=> in_a_term_en_o[3] && in_b_term_en_o[3])
    else $error("unselected channel lost termination");

  a_eq_map: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    clk_en_i |=> in_a_eq_high_o == $past(eq_app[3:0]) &&
      in_b_eq_high_o == {$past(eq_app[4]), $past(eq_app[5]),
                         $past(eq_app[6]), $past(eq_app[7])})
    else $error("equalizer bit mapping wrong");

  a_preemph: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    clk_en_i |=> output_preemph_level_o == $past(tx_app[3:2]))
    else $error("pre-emphasis level not taken from the field");

  a_out_term: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (clk_en_i && tx_app[1] != output_term_enable_o)
      |=> $changed(output_term_enable_o))
    else $error("output termination did not follow its bit");

  a_drive_cur: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    clk_en_i |=> output_drive_current_o == $past(tx_app[0]))
    else $error("drive current did not follow its bit");

  a_freeze: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !clk_en_i |=> $stable(pulse_cnt_r) && $stable(in_a_term_en_o))
    else $error("state moved while clock enable low");

endmodule : ltrx_settings_regs

// *** rtl/ltrx_consts.svh ***
// constants for the link switch receiver/transmitter settings registers
// assumes a 10 MHz system clock and byte-wide register offsets
`ifndef LTRX_CONSTS_SVH
`define LTRX_CONSTS_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define LTRX_CLK_HZ 10000000
`define LTRX_TERM_PULSE_MS 100
`define LTRX_UPD_DLY_CYC 16'h0040

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define LTRX_ADDR_RX_SET 8'h10
`define LTRX_ADDR_PULSE_SEL 8'h11
`define LTRX_ADDR_EQ_LVL 8'h13
`define LTRX_ADDR_TX_SET 8'h20

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LTRX_RST_RX_SET 8'h01
`define LTRX_RST_PULSE_SEL 8'h00
`define LTRX_RST_EQ_LVL 8'h00
`define LTRX_RST_TX_SET 8'h03

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LTRX_RX_TERM_BIT 0
`define LTRX_TX_CUR_BIT 0
`define LTRX_TX_TERM_BIT 1
`define LTRX_OUTPUT_PREEMPH_LEVEL_LSB 2
`define LTRX_OUTPUT_PREEMPH_LEVEL_MSB 3
`define LTRX_CH_PER_IN 4
`define LTRX_RD_ZERO 8'h00

`endif

// *** rtl/ltrx_pkg.sv ***
// types shared by the settings register logic
// assumes nothing beyond the constants header
package ltrx_pkg;

  typedef logic [7:0] ltrx_byte_t;

  // output pre-emphasis: 0, 2, 4 and 6 dB in code order
  typedef enum logic [1:0] {
    LTRX_PE_0DB,
    LTRX_PE_2DB,
    LTRX_PE_4DB,
    LTRX_PE_6DB
  } ltrx_preemph_t;

endpackage : ltrx_pkg

// *** rtl/ltrx_upd_delay.sv ***
// one register with its physical update delay window
// assumes writes arrive as one-cycle strobes in the sys_clk_i domain
`include "ltrx_consts.svh"

module ltrx_upd_delay
  import ltrx_pkg::*;
#(
  parameter ltrx_byte_t RST_VAL = 8'h00,
  parameter logic [15:0] DLY_CYC = `LTRX_UPD_DLY_CYC
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic wr_i,
  input wire ltrx_byte_t wdata_i,
  output ltrx_byte_t shadow_o,
  output ltrx_byte_t applied_o,
  output logic busy_o
);

  ltrx_byte_t shadow_r;
  ltrx_byte_t applied_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  ltrx_byte_t applied_nxt;
  ltrx_byte_t pend;
  wire busy = (cnt_r != 16'h0000);
  wire win_end = (cnt_r == 16'h0001);

  // ----------------------------------------------------------------------
  // window control
  // ----------------------------------------------------------------------
  // a write in the last window cycle still wins over the stored value
  assign pend = wr_i ? wdata_i : shadow_r;
  assign applied_nxt = (wr_i && !busy) ? wdata_i :
                       win_end ? pend : applied_r;
  assign cnt_nxt = (wr_i && !busy) ? DLY_CYC :
                   busy ? cnt_r - 16'h0001 : 16'h0000;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shadow_r <= RST_VAL;
      applied_r <= RST_VAL;
      cnt_r <= 16'h0000;
    end else if (clk_en_i) begin
      if (wr_i) begin
        shadow_r <= wdata_i;
      end
      applied_r <= applied_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign shadow_o = shadow_r;
  assign applied_o = applied_r;
  assign busy_o = busy;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_upd_hold: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (clk_en_i && wr_i && busy && !win_end) |=> applied_r == $past(applied_r))
    else $error("write inside the delay window applied early");

  a_upd_now: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (clk_en_i && wr_i && !busy) |=> applied_r == $past(wdata_i) && busy)
    else $error("write after the window not applied at once");

  a_upd_last: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (clk_en_i && win_end) |=> applied_r == $past(pend) && !busy)
    else $error("window end did not apply the last written value");

endmodule : ltrx_upd_delay

// *** testbench/ltrx_host_model.sv ***
// host side of the settings registers: byte reads and writes on strobes
// assumes the settings block samples its strobes on the rising clock edge

module ltrx_host_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------------
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // strobes stay up across back-to-back calls; idle drops them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(posedge sys_clk_i);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b1;
    reg_addr_o = a;
    @(posedge sys_clk_i);
    #1;
    d = reg_rdata_i;
  endtask : rd

  task automatic idle(input int n);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    repeat (n) begin
      @(posedge sys_clk_i);
      #1;
    end
  endtask : idle

endmodule : ltrx_host_model

// *** testbench/tb.sv ***
// self-checking bench for the settings registers
// assumes the host model drives the strobes; pulse and window shortened

module tb;
  import ltrx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int PULSE = 20;

  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic hs_sel = 1'b0;
  logic clk_en = 1'b1;
  logic reg_wr, reg_rd;
  ltrx_byte_t addr, wdata, rdata, rv;
  logic [3:0] a_term, b_term, a_eq, b_eq;
  ltrx_preemph_t pe;
  logic o_term, o_cur, p_act;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #50 sys_clk_i = ~sys_clk_i;

  ltrx_host_model host (.sys_clk_i(sys_clk_i), .reg_rdata_i(rdata),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata));

  ltrx_settings_regs #(.TERM_PULSE_CYC(PULSE), .UPD_DLY_CYC(16'h0004)) DUT (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .hs_src_sel_i(hs_sel), .reg_rdata_o(rdata),
    .in_a_term_en_o(a_term), .in_b_term_en_o(b_term),
    .in_a_eq_high_o(a_eq), .in_b_eq_high_o(b_eq),
    .output_preemph_level_o(pe), .output_term_enable_o(o_term),
    .output_drive_current_o(o_cur), .term_pulse_active_o(p_act));

  // ----------------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------------
  task automatic chk8(input ltrx_byte_t got, input ltrx_byte_t exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk4

  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      stop_test();
    end
  end

  // input B channel k follows register bit 7-k
  function automatic logic [3:0] bmap(input ltrx_byte_t v);
    return {v[4], v[5], v[6], v[7]};
  endfunction : bmap

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    ltrx_byte_t ra [5] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h20};
    ltrx_byte_t rd_def [5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h03};
    chk4(a_term & b_term, 4'hF);
    chk4(a_eq | b_eq, 4'h0);
    chk4({2'h0, pe}, 4'h0);
    chk4({2'h0, o_term, o_cur}, 4'h3);
    for (int i = 0; i < 5; i++) begin
      host.rd(ra[i], rv);
      chk8(rv, rd_def[i]);
    end
    host.idle(1);
  endtask : t_reset

  task automatic t_tx;
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h20, {4'h0, i[1:0], ~i[0], i[1]});
      host.idle(1);
      chk4({2'h0, pe}, {2'h0, i[1:0]});
      host.idle(7);
      chk4({2'h0, pe}, {2'h0, i[1:0]});
      chk4({3'h0, o_term}, {3'h0, ~i[0]});
      chk4({3'h0, o_cur}, {3'h0, i[1]});
    end
  endtask : t_tx

  task automatic t_eq_map;
    ltrx_byte_t pat [2] = '{8'h3A, 8'hC5};
    for (int i = 0; i < 2; i++) begin
      host.wr(8'h13, pat[i]);
      host.idle(8);
      chk4(a_eq, pat[i][3:0]);
      chk4(b_eq, bmap(pat[i]));
    end
  endtask : t_eq_map

  task automatic t_window;
    host.wr(8'h13, 8'h01);
    host.wr(8'h13, 8'h02);
    host.wr(8'h13, 8'h04);
    host.rd(8'h13, rv);
    chk8(rv, 8'h04);
    chk4(a_eq, 4'h1);
    host.idle(1);
    chk4(a_eq, 4'h1);
    host.idle(1);
    chk4(a_eq, 4'h4);
    host.idle(8);
    chk4(a_eq, 4'h4);
  endtask : t_window

  task automatic t_pulse;
    int n;
    host.wr(8'h11, 8'h81);
    host.idle(8);
    hs_sel = ~hs_sel;
    host.idle(3);
    chk4(a_term, 4'hE);
    chk4(b_term, 4'hE);
    chk4({3'h0, p_act}, 4'h1);
    host.idle(8);
    hs_sel = ~hs_sel;
    n = 0;
    while (p_act === 1'b1 && n < 200) begin
      host.idle(1);
      n++;
    end
    chk8(8'(n), 8'(PULSE + 2));
    chk4(a_term & b_term, 4'hF);
    host.wr(8'h10, 8'h00);
    host.idle(8);
    chk4(a_term | b_term, 4'h0);
    host.wr(8'h10, 8'h01);
    host.idle(8);
    chk4(a_term & b_term, 4'hF);
  endtask : t_pulse

  // strobes and settings must be ignored while the clock enable is low
  task automatic t_freeze;
    clk_en = 1'b0;
    host.wr(8'h20, 8'h00);
    host.rd(8'h20, rv);
    chk8(rv, 8'h04);
    host.idle(2);
    chk4({o_term, o_cur, pe}, 4'h7);
    clk_en = 1'b1;
    host.rd(8'h20, rv);
    chk8(rv, 8'h0D);
    host.wr(8'h12, 8'hFF);
    host.rd(8'h12, rv);
    chk8(rv, 8'h00);
    host.idle(8);
    chk4({o_term, o_cur, pe}, 4'h7);
  endtask : t_freeze

  task automatic t_rereset;
    nrst_i = 1'b0;
    host.idle(2);
    chk4(a_eq, 4'h0);
    nrst_i = 1'b1;
    host.idle(1);
    t_reset();
  endtask : t_rereset

  initial begin
    repeat (10) @(posedge sys_clk_i);
    #1;
    nrst_i = 1'b1;
    host.idle(1);
    t_reset();
    t_tx();
    t_eq_map();
    t_window();
    t_pulse();
    t_freeze();
    t_rereset();
    stop_test();
  end

endmodule : tb
